// [pkg/ccl_pkg.sv]
// ==========================================================================
// Clock control constants
package ccl_pkg;

   // ======================================================================
   // Register offsets on the plain register port
   localparam logic [3:0] CCL_OFF_SYNTH = 4'h0;
   localparam logic [3:0] CCL_OFF_PINASSIGN = 4'h1;
   localparam logic [3:0] CCL_OFF_HALT = 4'h2;
   localparam logic [3:0] CCL_OFF_STATUS = 4'h3;
   localparam logic [3:0] CCL_OFF_MULT = 4'h4;

   // ======================================================================
   // Synthesizer control field positions
   localparam int CCL_SYN_W = 15;
   localparam int CCL_SYN_X = 14;
   localparam int CCL_SYN_Y_HI = 13;
   localparam int CCL_SYN_Y_LO = 8;
   localparam int CCL_SYN_PERIPH_CLOCK_DIVIDE_SEL = 7;
   localparam int CCL_SYN_LOCK = 3;
   localparam int CCL_SYN_KEEPOSC = 2;
   localparam int CCL_SYN_CLKPIN = 1;
   localparam logic [15:0] CCL_SYN_WMASK = 16'hFF86;

   // Pin assignment bit enabling the peripheral clock on the top address pin
   localparam int CCL_PA_PCLK = 4;

   // Status field positions
   localparam int CCL_ST_SLEEP = 0;
   localparam int CCL_ST_MODE = 1;
   localparam int CCL_ST_MASK_LO = 4;

   // ======================================================================
   // Reset values
   localparam logic [15:0] CCL_SYN_RESET = 16'h3F00;
   localparam logic [15:0] CCL_PA_RESET = 16'h0000;

   // ======================================================================
   // Counts
   localparam logic [7:0] CCL_LOCK_CYCLES = 8'h40;
   localparam logic [2:0] CCL_PDIV8_HALF = 3'h3;
   localparam logic [2:0] CCL_PDIV16_HALF = 3'h7;

   // ======================================================================
   // Clock source selection codes
   typedef enum logic [1:0] {
      CCL_SRC_OFF = 2'h0,
      CCL_SRC_EXT = 2'h1,
      CCL_SRC_REF = 2'h2,
      CCL_SRC_VCO = 2'h3
   } ccl_src_t;

   // Power states
   typedef enum logic [1:0] {
      CCL_RUN = 2'b01,
      CCL_SLEEP = 2'b10
   } ccl_state_t;

endpackage : ccl_pkg

// [verification/ccl_core_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// Processor core side: sleep broadcast and interrupt levels
module ccl_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bench requests
   input wire logic stop_req,
   input wire logic [2:0] stop_mask,
   input wire logic [2:0] irq_req,
   // Lines towards the block
   output logic sleep_cycle,
   output logic [2:0] sleep_mask,
   output logic [2:0] irq_level_pin
);
   // One-cycle broadcast carrying the mask, then mask lines wander
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sleep_cycle <= 1'b0;
         sleep_mask <= 3'h0;
         irq_level_pin <= 3'h0;
      end else begin
         sleep_cycle <= stop_req;
         sleep_mask <= stop_req ? stop_mask : ~sleep_mask;
         irq_level_pin <= irq_req;
      end
   end
endmodule : ccl_core_model

// [verification/tb_clock_synth_lowpower_control.sv]
`timescale 1ns/1ps
// ==========================================================================
// Testbench
module tb_clock_synth_lowpower_control;
   import ccl_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, mode = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, rv, prev, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, ext_c = 1'b0, ref_c = 1'b0, vco_c = 1'b0;
   logic stop_req = 1'b0;
   logic [2:0] stop_mask = 3'h0, irq_req = 3'h0, sleep_mask, irq_level_pin;
   logic sleep_cycle, sys_clk, integration_clock, clock_output_pin, peripheral_bus_clock;
   logic top_address_pin, top_address_is_clock, pit_tick, sleeping, synth_locked_flag;
   logic synth_relock;
   logic [7:0] module_clk_en;
   logic [11:0] sys_multiplier;
   logic [15:0] syn_v [5] = '{16'h0000, 16'h4100, 16'h8700, 16'hFF00, 16'hBF00};
   int fail_count = 0, samples_checked = 0, cyc = 0, m;
   int n_sys, n_int, n_out, n_pc, n_top, n_pit;
   logic chg;

   // Clock and source oscillators (vco /4, ext /6, ref /10)
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      vco_c <= cyc[1];
      ext_c <= (cyc % 6) < 3;
      ref_c <= (cyc % 10) < 5;
   end

   ccl_clock_control dut (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sleep_cycle(sleep_cycle), .sleep_mask(sleep_mask), .ext_clk_pin(ext_c),
      .ref_clk_pin(ref_c), .vco_clk_pin(vco_c), .clock_mode_pin(mode),
      .irq_level_pin(irq_level_pin), .sys_clk(sys_clk), .integration_clock(integration_clock),
      .clock_output_pin(clock_output_pin), .peripheral_bus_clock(peripheral_bus_clock),
      .top_address_pin(top_address_pin), .top_address_is_clock(top_address_is_clock),
      .module_clk_en(module_clk_en), .pit_tick(pit_tick), .sleeping(sleeping),
      .synth_locked_flag(synth_locked_flag), .synth_relock(synth_relock),
      .sys_multiplier(sys_multiplier));

   ccl_core_model core (.clk(clk), .nrst(nrst), .stop_req(stop_req), .stop_mask(stop_mask),
      .irq_req(irq_req), .sleep_cycle(sleep_cycle), .sleep_mask(sleep_mask),
      .irq_level_pin(irq_level_pin));

   // ======================================================================
   // Register port, one-cycle write and read accesses
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // ======================================================================
   // Compare and report
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task chr(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chr

   task stop_test;
      $display("counts fail=%0d checked=%0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // Bounded wait on sleeping (w=0) or lock flag (w=1)
   task waitv(input int w, input logic v);
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge clk);
         #1;
         if ((w == 1 ? synth_locked_flag : sleeping) === v) break;
      end
      if (i == 200) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, ~v, v);
         stop_test();
      end
   endtask : waitv

   // Count rising edges of the output clocks over n cycles
   task act(input int n);
      logic [4:0] p, c, r;
      p = {top_address_pin, peripheral_bus_clock, clock_output_pin, integration_clock, sys_clk};
      {n_sys, n_int, n_out, n_pc, n_top, n_pit} = '0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1;
         c = {top_address_pin, peripheral_bus_clock, clock_output_pin, integration_clock, sys_clk};
         r = c & ~p;
         n_sys += r[0];
         n_int += r[1];
         n_out += r[2];
         n_pc += r[3];
         n_top += r[4];
         n_pit += pit_tick;
         p = c;
      end
   endtask : act

   task sleep(input logic [2:0] msk);
      @(posedge clk);
      stop_req <= 1'b1;
      stop_mask <= msk;
      @(posedge clk);
      stop_req <= 1'b0;
      waitv(0, 1'b1);
   endtask : sleep

   // ======================================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(CCL_OFF_SYNTH, rv); chk(rv, CCL_SYN_RESET | 16'h0008);
      rd(CCL_OFF_MULT, rv); chk(rv, 16'h0100);
      rd(CCL_OFF_STATUS, rv); chk(rv, 16'h0002);
      wr(CCL_OFF_SYNTH, 16'h3F71);
      rd(CCL_OFF_SYNTH, rv); chk(rv, (16'h3F71 & CCL_SYN_WMASK) | 16'h0008);
      wr(4'h5, 16'hFFFF);
      rd(4'h5, rv); chk(rv, 16'h0000);
      $display("test reset done");
      prev = CCL_SYN_RESET;
      for (int i = 0; i < 5; i++) begin
         m = (4 * (int'(syn_v[i][13:8]) + 1)) << (2 * syn_v[i][15] + syn_v[i][14]);
         chg = (syn_v[i][15] !== prev[15]) || (syn_v[i][13:8] !== prev[13:8]);
         wr(CCL_OFF_SYNTH, syn_v[i]);
         repeat (2) @(posedge clk);
         #1;
         chk({15'h0, synth_locked_flag}, {15'h0, ~chg});
         chk({15'h0, synth_relock}, {15'h0, chg});
         waitv(1, 1'b1);
         rd(CCL_OFF_MULT, rv); chk(rv, m[15:0]);
         chk({4'h0, sys_multiplier}, m[15:0]);
         prev = syn_v[i];
      end
      wr(CCL_OFF_SYNTH, 16'h3F00);
      waitv(1, 1'b1);
      $display("test multiplier done");
      for (int e = 0; e < 2; e++) begin
         wr(CCL_OFF_SYNTH, 16'h3F00 | (16'h0080 * e));
         act(400);
         chr(n_pc, n_sys / (8 << e) - 1, n_sys / (8 << e) + 1);
         chr(n_top, 0, 0);
      end
      wr(CCL_OFF_PINASSIGN, 16'h0001 << CCL_PA_PCLK);
      act(400);
      chk({15'h0, top_address_is_clock}, 16'h0001);
      chr(n_top, n_pc - 1, n_pc + 1);
      wr(CCL_OFF_HALT, 16'h0005);
      rd(CCL_OFF_HALT, rv); chk(rv, 16'h0005);
      chk({8'h00, module_clk_en}, 16'h00FA);
      $display("test divider done");
      wr(CCL_OFF_SYNTH, 16'h3F06);
      sleep(3'h3);
      rd(CCL_OFF_STATUS, rv); chk(rv, 16'h0033);
      chk({8'h00, module_clk_en}, 16'h0000);
      act(100);
      chr(n_sys, 0, 0);
      chk({15'h0, sys_clk}, 16'h0000);
      chr(n_pc, 0, 0);
      chr(n_int, 23, 27);
      chr(n_out, 23, 27);
      chr(n_pit, n_int - 1, n_int + 1);
      irq_req <= 3'h3;
      act(50);
      chk({15'h0, sleeping}, 16'h0001);
      irq_req <= 3'h4;
      waitv(0, 1'b0);
      chk({8'h00, module_clk_en}, 16'h00FA);
      irq_req <= 3'h0;
      wr(CCL_OFF_SYNTH, 16'h3F00);
      sleep(3'h6);
      sleep(3'h1);
      rd(CCL_OFF_STATUS, rv); chk(rv, 16'h0063);
      act(100);
      chr(n_int, 9, 11);
      chr(n_out, 0, 0);
      chk({15'h0, clock_output_pin}, 16'h0000);
      irq_req <= 3'h7;
      waitv(0, 1'b0);
      act(100);
      chr(n_int, 23, 27);
      chr(n_out, 23, 27);
      irq_req <= 3'h0;
      $display("test sleep oscillator done");
      mode <= 1'b0;
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd(CCL_OFF_STATUS, rv); chk(rv, 16'h0000);
      act(100);
      chr(n_int, 15, 18);
      chr(n_out, 15, 18);
      sleep(3'h2);
      act(100);
      chr(n_int, 15, 18);
      chr(n_out, 0, 0);
      nrst <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk({15'h0, sleeping}, 16'h0000);
      nrst <= 1'b1;
      $display("test sleep external done");
      stop_test();
   end
endmodule : tb_clock_synth_lowpower_control

// [verilog/ccl_clk_switch.sv]
`timescale 1ns/1ps
// ==========================================================================
// Glitch-free clock source switch
module ccl_clk_switch
   import ccl_pkg::*;
(
   // Clock and control
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Source levels, bit 0 unused (off)
   input wire logic [3:0] src,
   input wire ccl_src_t sel_req,
   // Switched clock
   output logic clk_out
);

   typedef struct packed {
      ccl_src_t cur;
      logic out;
   } ccl_sw_t;

   ccl_sw_t s_q;
   ccl_sw_t s_d;

   // Switch only while output and new source are both low
   always_comb begin
      s_d = s_q;
      if (sel_req != s_q.cur && !s_q.out && !src[sel_req]) begin // RQ19
         s_d.cur = sel_req;
      end
      s_d.out = (s_d.cur == CCL_SRC_OFF) ? 1'b0 : src[s_d.cur]; // RQ14
      if (!nrst) begin
         s_d.cur = CCL_SRC_OFF;
         s_d.out = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (ce) begin
         s_q <= s_d;
      end
   end

   assign clk_out = s_q.out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !ce);

   a_switch_no_glitch: assert property ( // RQ19
      $changed(s_q.cur) |-> !s_q.out && !$past(s_q.out))
      else $error("source switched while output high");

endmodule : ccl_clk_switch

// [verilog/ccl_clock_control.sv]
`timescale 1ns/1ps
//
// Behaviour
// RQ1 - System multiplier follows six-bit modulus and two prescaler bits; all ones gives 2048.
// RQ2 - Peripheral bus clock is system clock divided by eight or sixteen.
// RQ3 - Peripheral clock reaches top address pin only when pin assignment bit 4 set.
// RQ4 - Halt bit stops a module's clock; its registers stay accessible.
// RQ5 - Deep-sleep instruction turns the system clock off.
// RQ6 - Processor broadcasts its interrupt mask on sleep entry; block stores it.
// RQ7 - Interrupt above stored mask, or reset, ends sleep and restores system clock.
// RQ8 - Control logic and integration clock keep running in sleep, barring lost external.
// RQ9 - Timer tick and pin input logic run from the integration clock.
// RQ10 - Awake: integration and output clocks from external (mode low) or oscillator.
// RQ11 - Asleep with synthesizer: integration clock from oscillator or reference per keep bit.
// RQ12 - Asleep: clock output off unless enable bit set, then same as integration.
// RQ13 - Source mode is the clock-mode pin level at the latest reset.
// RQ14 - Every clock that is off is held low.
// RQ15 - Frequency is reference times 4(modulus+1) times 2^(2*speed+divider).
// RQ16 - After reset control selects modulus 63, multiplier 256.
// RQ17 - Divider bit changes need no relock; speed or modulus change forces relock.
// RQ18 - Software touches synthesizer control only at supervisor privilege; the register port here has no privilege check and takes any write.
// RQ19 - Source changes at sleep entry and exit produce no glitches.
// RQ20 - Wake compare runs on the integration clock, not the system clock.
//
module ccl_clock_control
   import ccl_pkg::*;
#(
   parameter int NMOD = 8
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Processor side
   input wire logic sleep_cycle,
   input wire logic [2:0] sleep_mask,
   // Pins
   input wire logic ext_clk_pin,
   input wire logic ref_clk_pin,
   input wire logic vco_clk_pin,
   input wire logic clock_mode_pin,
   input wire logic [2:0] irq_level_pin,
   // Clocks out
   output logic sys_clk,
   output logic integration_clock,
   output logic clock_output_pin,
   output logic peripheral_bus_clock,
   output logic top_address_pin,
   output logic top_address_is_clock,
   output logic [NMOD-1:0] module_clk_en,
   output logic pit_tick,
   // Status
   output logic sleeping,
   output logic synth_locked_flag,
   output logic synth_relock,
   output logic [11:0] sys_multiplier
);

   // =======================================================================
   // State
   typedef struct packed {
      logic [1:0] ext_s;
      logic [1:0] ref_s;
      logic [1:0] vco_s;
      logic [1:0] mode_s;
      logic [2:0] irq_s0;
      logic [2:0] irq_s1;
      logic mode;
      logic rst_seen;
      logic [15:0] synth;
      logic [15:0] pin_assign;
      logic [NMOD-1:0] halt;
      ccl_state_t state;
      logic [2:0] mask;
      logic [7:0] lock_cnt;
      logic relock;
      logic sys_prev;
      logic integ_prev;
      logic [2:0] pdiv;
      logic pclk;
      logic addr_clk;
      logic addr_is_clk;
      logic [NMOD-1:0] mod_en;
      logic pit;
      logic [15:0] rdata;
      logic [11:0] mult;
   } ccl_state_reg_t;

   ccl_state_reg_t s_q;
   ccl_state_reg_t s_d;

   ccl_src_t sys_sel;
   ccl_src_t integ_sel;
   ccl_src_t out_sel;
   logic [3:0] srcs;
   logic sys_clk_w;
   logic integ_clk_w;
   logic out_clk_w;

   // Multiplier from modulus and prescalers
   function automatic logic [11:0] mult_of(input logic [15:0] syn);
      logic [11:0] base;
      logic [1:0] sh;
      base = {4'h0, ({2'b00, syn[CCL_SYN_Y_HI:CCL_SYN_Y_LO]} + 8'h01)} << 2;
      sh = {syn[CCL_SYN_W], 1'b0} + {1'b0, syn[CCL_SYN_X]};
      mult_of = base << sh;
   endfunction : mult_of

   // =======================================================================
   // Source selection
   assign srcs = {s_q.vco_s[1], s_q.ref_s[1], s_q.ext_s[1], 1'b0};

   always_comb begin
      sys_sel = CCL_SRC_OFF;
      integ_sel = s_q.mode ? CCL_SRC_VCO : CCL_SRC_EXT; // RQ10 RQ13
      if (s_q.state == CCL_RUN) begin
         sys_sel = s_q.mode ? CCL_SRC_VCO : CCL_SRC_EXT;
      end
      if (s_q.state == CCL_SLEEP && s_q.mode && !s_q.synth[CCL_SYN_KEEPOSC]) begin
         integ_sel = CCL_SRC_REF; // RQ11
      end
      out_sel = integ_sel;
      if (s_q.state == CCL_SLEEP && !s_q.synth[CCL_SYN_CLKPIN]) begin
         out_sel = CCL_SRC_OFF; // RQ12
      end
   end

   // System clock: off while asleep
   ccl_clk_switch u_sys_sw ( // RQ5 RQ19
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .src(srcs),
      .sel_req(sys_sel),
      .clk_out(sys_clk_w)
   );

   // Integration clock keeps running in sleep
   ccl_clk_switch u_integ_sw ( // RQ8
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .src(srcs),
      .sel_req(integ_sel),
      .clk_out(integ_clk_w)
   );

   // Clock output pin
   ccl_clk_switch u_out_sw ( // RQ12
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .src(srcs),
      .sel_req(out_sel),
      .clk_out(out_clk_w)
   );

   // =======================================================================
   // Next state
   always_comb begin
      logic sys_rise;
      logic integ_rise;
      logic [2:0] half;
      sys_rise = 1'b0;
      integ_rise = 1'b0;
      half = 3'h0;
      s_d = s_q;

      // Pin synchronisers
      s_d.ext_s = {s_q.ext_s[0], ext_clk_pin};
      s_d.ref_s = {s_q.ref_s[0], ref_clk_pin};
      s_d.vco_s = {s_q.vco_s[0], vco_clk_pin};
      s_d.mode_s = {s_q.mode_s[0], clock_mode_pin};
      s_d.irq_s0 = irq_level_pin;
      s_d.irq_s1 = s_q.irq_s0;

      sys_rise = sys_clk_w && !s_q.sys_prev;
      integ_rise = integ_clk_w && !s_q.integ_prev;
      s_d.sys_prev = sys_clk_w;
      s_d.integ_prev = integ_clk_w;

      // Timer tick from integration clock edges
      s_d.pit = integ_rise; // RQ9

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            CCL_OFF_SYNTH: begin
               s_d.synth = (reg_wdata & CCL_SYN_WMASK) | (s_q.synth & ~CCL_SYN_WMASK);
               if (reg_wdata[CCL_SYN_W] != s_q.synth[CCL_SYN_W] ||
                   reg_wdata[CCL_SYN_Y_HI:CCL_SYN_Y_LO] !=
                   s_q.synth[CCL_SYN_Y_HI:CCL_SYN_Y_LO]) begin
                  s_d.lock_cnt = CCL_LOCK_CYCLES; // RQ17
               end
            end
            CCL_OFF_PINASSIGN: begin
               s_d.pin_assign = reg_wdata;
            end
            CCL_OFF_HALT: begin
               s_d.halt = reg_wdata[NMOD-1:0]; // RQ4
            end
            default: begin
            end
         endcase
      end

      // Relock countdown
      if (s_d.lock_cnt == s_q.lock_cnt && s_q.lock_cnt != 8'h00) begin
         s_d.lock_cnt = s_q.lock_cnt - 8'h01;
      end
      s_d.relock = (s_d.lock_cnt != 8'h00);
      s_d.synth[CCL_SYN_LOCK] = (s_d.lock_cnt == 8'h00);
      s_d.mult = mult_of(s_d.synth); // RQ1 RQ15

      // Sleep state machine
      unique case (s_q.state)
         CCL_RUN: begin
            if (sleep_cycle) begin
               s_d.mask = sleep_mask; // RQ6
               s_d.state = CCL_SLEEP; // RQ5
            end
         end
         CCL_SLEEP: begin
            if (integ_rise && s_q.irq_s1 > s_q.mask) begin // RQ7 RQ20
               s_d.state = CCL_RUN;
            end
         end
      endcase

      // Peripheral bus clock from system clock edges
      half = s_q.synth[CCL_SYN_PERIPH_CLOCK_DIVIDE_SEL] ? CCL_PDIV16_HALF : CCL_PDIV8_HALF;
      if (s_d.state == CCL_SLEEP) begin
         s_d.pdiv = 3'h0;
         s_d.pclk = 1'b0; // RQ14
      end else if (sys_rise) begin
         if (s_q.pdiv >= half) begin // RQ2
            s_d.pdiv = 3'h0;
            s_d.pclk = !s_q.pclk;
         end else begin
            s_d.pdiv = s_q.pdiv + 3'h1;
         end
      end
      s_d.addr_is_clk = s_q.pin_assign[CCL_PA_PCLK]; // RQ3
      s_d.addr_clk = s_q.pin_assign[CCL_PA_PCLK] && s_d.pclk; // RQ3

      // Module clock enables
      s_d.mod_en = (s_d.state == CCL_RUN) ? ~s_q.halt : '0; // RQ4

      // Register reads
      s_d.rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            CCL_OFF_SYNTH: s_d.rdata = s_q.synth;
            CCL_OFF_PINASSIGN: s_d.rdata = s_q.pin_assign;
            CCL_OFF_HALT: s_d.rdata = {{(16-NMOD){1'b0}}, s_q.halt};
            CCL_OFF_STATUS: begin
               s_d.rdata[CCL_ST_SLEEP] = (s_q.state == CCL_SLEEP);
               s_d.rdata[CCL_ST_MODE] = s_q.mode;
               s_d.rdata[CCL_ST_MASK_LO +: 3] = s_q.mask;
            end
            CCL_OFF_MULT: s_d.rdata = {4'h0, s_q.mult};
            default: s_d.rdata = 16'h0000;
         endcase
      end

      // Mode pin taken again on the edge after reset, once its sync is full
      if (s_q.rst_seen) begin
         s_d.mode = s_q.mode_s[1]; // RQ13
      end
      s_d.rst_seen = !nrst;
      // Synchronous reset: mode pin captured while reset is held
      if (!nrst) begin
         s_d.mode = s_q.mode_s[1]; // RQ13
         s_d.synth = CCL_SYN_RESET; // RQ16
         s_d.pin_assign = CCL_PA_RESET;
         s_d.halt = '0;
         s_d.state = CCL_RUN; // RQ7
         s_d.mask = 3'h0;
         s_d.lock_cnt = 8'h00;
         s_d.relock = 1'b0;
         s_d.sys_prev = 1'b0;
         s_d.integ_prev = 1'b0;
         s_d.pdiv = 3'h0;
         s_d.pclk = 1'b0;
         s_d.addr_clk = 1'b0;
         s_d.addr_is_clk = 1'b0;
         s_d.mod_en = '0;
         s_d.pit = 1'b0;
         s_d.rdata = 16'h0000;
         s_d.mult = mult_of(CCL_SYN_RESET);
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (ce) begin
         s_q <= s_d;
      end
   end

   // =======================================================================
   // Outputs
   assign reg_rdata = s_q.rdata;
   assign sys_clk = sys_clk_w;
   assign integration_clock = integ_clk_w;
   assign clock_output_pin = out_clk_w;
   assign peripheral_bus_clock = s_q.pclk;
   assign top_address_pin = s_q.addr_clk;
   assign top_address_is_clock = s_q.addr_is_clk;
   assign module_clk_en = s_q.mod_en;
   assign pit_tick = s_q.pit;
   assign sleeping = s_q.state[1]; // One-hot sleep flop
   assign synth_locked_flag = s_q.synth[CCL_SYN_LOCK];
   assign synth_relock = s_q.relock;
   assign sys_multiplier = s_q.mult;

   // =======================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !ce);

   a_mult_formula: assert property ( // RQ15
      s_q.mult == (({4'h0, s_q.synth[CCL_SYN_Y_HI:CCL_SYN_Y_LO], 2'b00} + 12'h004)
         << s_q.synth[CCL_SYN_W:CCL_SYN_X]))
      else $error("multiplier does not match control fields");
   a_mult_max: assert property ( // RQ1
      s_q.synth[15:8] == 8'hFF |-> s_q.mult == 12'h800)
      else $error("full setting not 2048");
   a_reset_default: assert property ( // RQ16
      $past(!nrst) |-> s_q.mult == 12'h100)
      else $error("reset multiplier not 256");
   a_sleep_entry: assert property ( // RQ6
      s_q.state == CCL_RUN && sleep_cycle |=> sleeping && s_q.mask == $past(sleep_mask))
      else $error("mask not stored on sleep entry");
   a_sysclk_off: assert property ( // RQ5
      sleeping [*5] |-> !sys_clk)
      else $error("system clock runs in sleep");
   a_wake_prio: assert property ( // RQ7
      sleeping && s_q.irq_s1 > s_q.mask |-> ##[1:24] !sleeping)
      else $error("no wake on higher interrupt");
   a_no_wake_low: assert property ( // RQ20
      sleeping && s_q.irq_s1 <= s_q.mask |=> sleeping)
      else $error("woke without higher interrupt");
   a_addr_gate: assert property ( // RQ3
      !s_q.pin_assign[CCL_PA_PCLK] |=> !top_address_pin)
      else $error("address pin clocked while not assigned");
   a_halt_gate: assert property ( // RQ4
      s_q.halt != '0 |=> (module_clk_en & $past(s_q.halt)) == '0)
      else $error("halted module still clocked");
   a_clkpin_off: assert property ( // RQ12
      (sleeping && !s_q.synth[CCL_SYN_CLKPIN]) [*5] |-> !clock_output_pin)
      else $error("clock output runs while disabled");
   a_relock: assert property ( // RQ17
      reg_wr && reg_addr == CCL_OFF_SYNTH &&
      reg_wdata[CCL_SYN_Y_HI:CCL_SYN_Y_LO] != s_q.synth[CCL_SYN_Y_HI:CCL_SYN_Y_LO]
      |=> !synth_locked_flag [*8])
      else $error("modulus change did not force relock");
   a_pclk_sleep: assert property ( // RQ14
      sleeping |-> !peripheral_bus_clock)
      else $error("peripheral clock high while off");

endmodule : ccl_clock_control
